// ### rtl/sltx_consts.vh
`ifndef SLTX_CONSTS_VH
`define SLTX_CONSTS_VH

// register offsets (byte addresses on the plain port)
`define SLTX_ADDR_W 12
`define SLTX_OFF_LINK_EN 12'h200
`define SLTX_OFF_SOFT_SYNC 12'h203
`define SLTX_OFF_CONTROL 12'h204
`define SLTX_OFF_PATTERN 12'h205
`define SLTX_OFF_DEV_ID 12'h206
`define SLTX_OFF_FRAME_SYM 12'h207
`define SLTX_OFF_STATUS 12'h208
`define SLTX_OFF_TS_RECV 12'h20c

// reset values
`define SLTX_RST_CONTROL 8'h02
`define SLTX_RST_PATTERN 8'h00
`define SLTX_RST_DEV_ID 8'h00
`define SLTX_RST_FRAME_SYM 8'h00
`define SLTX_RST_LINK_EN 1'h1
`define SLTX_RST_SOFT_SYNC 1'h1

// field positions
`define SLTX_CTL_WHITEN 0
`define SLTX_CTL_FORMAT 1
`define SLTX_CTL_SYNC_LO 2
`define SLTX_CTL_SYNC_HI 3
`define SLTX_ST_PLL 2
`define SLTX_ST_ALIGNED 3
`define SLTX_ST_REALIGNED 4
`define SLTX_ST_SYNC 5
`define SLTX_ST_LINK_UP 6
`define SLTX_BIT_FLAG 0
`define SLTX_PAT_MSB 3
`define SLTX_ID_IGNORED 0
`define SLTX_RST_TS_RECV 1'h0

// sync source codes
`define SLTX_SYNC_SE 2'h0
`define SLTX_SYNC_TS 2'h1
`define SLTX_SYNC_SOFT 2'h2

// lane pattern modes
`define SLTX_PAT_NORMAL 4'h0
`define SLTX_PAT_PRBS7 4'h1
`define SLTX_PAT_PRBS15 4'h2
`define SLTX_PAT_PRBS23 4'h3
`define SLTX_PAT_RAMP 4'h4
`define SLTX_PAT_TRANSPORT 4'h5
`define SLTX_PAT_D215 4'h6
`define SLTX_PAT_K285 4'h7
`define SLTX_PAT_ILA 4'h8
`define SLTX_PAT_RPAT 4'h9
`define SLTX_PAT_LOW 4'ha
`define SLTX_PAT_HIGH 4'hb

// end-of-frame symbols as 8-bit data
`define SLTX_FS_K287 2'h0
`define SLTX_FS_K281 2'h1
`define SLTX_FS_K285 2'h2
`define SLTX_SYM_K287 8'hfc
`define SLTX_SYM_K281 8'h3c
`define SLTX_SYM_K285 8'hbc
`define SLTX_SYM_D215 8'hb5

`endif

// ### rtl/sltx_regs.v
`include "sltx_consts.vh"

module sltx_regs (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // register port
  input wire [11:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // pins from outside the clock domain
  input wire single_ended_sync_pin_in,
  input wire timestamp_diff_pin_in,
  input wire pll_locked_in,
  // same-domain events from the link core
  input wire link_up_in,
  input wire sysref_realign_in,
  input wire sysref_event_in,
  input wire frame_end_ok_in,
  // steering to the link core
  output reg link_enable_out,
  output reg link_reset_n_out,
  output reg serializer_pd_out,
  output reg sync_request_n_out,
  output reg sample_code_form_out,
  output reg whitening_enable_out,
  output reg [3:0] lane_pattern_mode_out,
  output reg lane_force_low_out,
  output reg lane_force_high_out,
  output reg [7:0] link_a_dev_id_out,
  output reg [7:0] link_b_dev_id_out,
  output reg [7:0] end_of_frame_symbol_out,
  output reg frame_end_insert_out,
  output reg timestamp_receiver_enable_out
);
  reg [7:0] link_control_reg;
  reg [7:0] test_pattern_select_reg;
  reg [7:0] device_identifier_param_reg;
  reg [7:0] frame_end_symbol_select_reg;
  reg link_enable_reg;
  reg soft_sync_request_n_reg;
  reg ts_recv_en_reg;
  reg aligned_reg;
  reg realigned_reg;
  reg aligned_armed_reg;
  wire se_sync;
  wire ts_sync;
  wire pll_sync;
  reg sync_n_next;
  reg [7:0] status_next;
  reg [7:0] rdata_next;
  reg [7:0] eof_next;

  // address match, shared by write and read decode
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // map the frame symbol code to its character
  function [7:0] eof_symbol;
    input [1:0] code;
    begin
      case (code)
        `SLTX_FS_K281: eof_symbol = `SLTX_SYM_K281;
        `SLTX_FS_K285: eof_symbol = `SLTX_SYM_K285;
        default: eof_symbol = `SLTX_SYM_K287; // reserved falls back to k28.7
      endcase
    end
  endfunction

  sltx_sync2 u_se_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(single_ended_sync_pin_in),
    .sync_out(se_sync)
  );

  sltx_sync2 u_ts_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(timestamp_diff_pin_in),
    .sync_out(ts_sync)
  );

  sltx_sync2 u_pll_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(pll_locked_in),
    .sync_out(pll_sync)
  );

  // sync request: pin or software, software always able to request
  always @* begin
    case (link_control_reg[`SLTX_CTL_SYNC_HI:`SLTX_CTL_SYNC_LO])
      `SLTX_SYNC_SE: sync_n_next = se_sync & soft_sync_request_n_reg;
      // without receiver enable the pin path is dead, held asserted
      `SLTX_SYNC_TS: sync_n_next = ts_sync & ts_recv_en_reg & soft_sync_request_n_reg;
      `SLTX_SYNC_SOFT: sync_n_next = soft_sync_request_n_reg;
      default: sync_n_next = soft_sync_request_n_reg;
    endcase
  end

  // live status view; reserved bits read zero
  always @* begin
    status_next = 8'h00;
    status_next[`SLTX_ST_LINK_UP] = link_up_in & link_enable_reg;
    status_next[`SLTX_ST_SYNC] = sync_request_n_out;
    status_next[`SLTX_ST_REALIGNED] = realigned_reg;
    status_next[`SLTX_ST_ALIGNED] = aligned_reg;
    status_next[`SLTX_ST_PLL] = pll_sync;
  end

  // read mux, registered so data stand the cycle after the strobe
  always @* begin
    rdata_next = 8'h00;
    if (hit(addr_in, `SLTX_OFF_LINK_EN))
      rdata_next = {7'h00, link_enable_reg};
    else if (hit(addr_in, `SLTX_OFF_SOFT_SYNC))
      rdata_next = {7'h00, soft_sync_request_n_reg};
    else if (hit(addr_in, `SLTX_OFF_CONTROL))
      rdata_next = link_control_reg;
    else if (hit(addr_in, `SLTX_OFF_PATTERN))
      rdata_next = test_pattern_select_reg;
    else if (hit(addr_in, `SLTX_OFF_DEV_ID))
      rdata_next = device_identifier_param_reg;
    else if (hit(addr_in, `SLTX_OFF_FRAME_SYM))
      rdata_next = frame_end_symbol_select_reg;
    else if (hit(addr_in, `SLTX_OFF_STATUS))
      rdata_next = status_next;
    else if (hit(addr_in, `SLTX_OFF_TS_RECV))
      rdata_next = {7'h00, ts_recv_en_reg};
  end

  // frame symbol choice
  always @* begin
    eof_next = eof_symbol(frame_end_symbol_select_reg[1:0]);
  end

  // write decode shared by every register except status, whose flag clears decode the address in place
  function wr_hit;
    input en;
    input wr;
    input [11:0] a;
    input [11:0] off;
    begin
      wr_hit = en & wr & (a == off);
    end
  endfunction

  // one strobe per register; a write while the clock enable is low is lost
  wire wr_link_en = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_LINK_EN);
  wire wr_soft_sync = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_SOFT_SYNC);
  wire wr_control = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_CONTROL);
  wire wr_pattern = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_PATTERN);
  wire wr_dev_id = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_DEV_ID);
  wire wr_frame_sym = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_FRAME_SYM);
  wire wr_ts_recv = wr_hit(ce_in, wr_in, addr_in, `SLTX_OFF_TS_RECV);

  // control: sync source, sample format, scrambler; settings take writes
  // at any time, keeping them still while the link runs is left to software,
  // which saves a shadow copy of every field
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_control_reg <= `SLTX_RST_CONTROL;
    end else if (wr_control) begin
      link_control_reg <= wdata_in;
    end
  end

  // lane pattern select; upper bits kept so software reads back its write
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      test_pattern_select_reg <= `SLTX_RST_PATTERN;
    end else if (wr_pattern) begin
      test_pattern_select_reg <= wdata_in;
    end
  end

  // device id; the ignored bit is cleared on the way in, so it reads 0
  // and link b can add one without a carry
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      device_identifier_param_reg <= `SLTX_RST_DEV_ID;
    end else if (wr_dev_id) begin
      device_identifier_param_reg <= wdata_in & ~(8'h01 << `SLTX_ID_IGNORED);
    end
  end

  // frame-end symbol select
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_end_symbol_select_reg <= `SLTX_RST_FRAME_SYM;
    end else if (wr_frame_sym) begin
      frame_end_symbol_select_reg <= wdata_in;
    end
  end

  // link enable; clearing it is the only way to park the link core
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_enable_reg <= `SLTX_RST_LINK_EN;
    end else if (wr_link_en) begin
      link_enable_reg <= wdata_in[`SLTX_BIT_FLAG];
    end
  end

  // software sync request, active low; left at 1 for normal running
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      soft_sync_request_n_reg <= `SLTX_RST_SOFT_SYNC;
    end else if (wr_soft_sync) begin
      soft_sync_request_n_reg <= wdata_in[`SLTX_BIT_FLAG];
    end
  end

  // timestamp receiver enable; the timestamp sync source is dead without it
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ts_recv_en_reg <= `SLTX_RST_TS_RECV;
    end else if (wr_ts_recv) begin
      ts_recv_en_reg <= wdata_in[`SLTX_BIT_FLAG];
    end
  end

  // sticky alignment flags: hardware set beats a same-cycle clear
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      aligned_reg <= 1'b0;
      realigned_reg <= 1'b0;
      aligned_armed_reg <= 1'b1;
    end else if (ce_in) begin
      if (!link_enable_reg) begin
        aligned_armed_reg <= 1'b1; // sysref ignored while disabled
      end else if (sysref_event_in && aligned_armed_reg) begin
        aligned_reg <= 1'b1;
        aligned_armed_reg <= 1'b0;
      end else if (wr_in && hit(addr_in, `SLTX_OFF_STATUS) && wdata_in[`SLTX_ST_ALIGNED]) begin
        aligned_reg <= 1'b0;
      end
      if (link_enable_reg && sysref_realign_in)
        realigned_reg <= 1'b1;
      else if (wr_in && hit(addr_in, `SLTX_OFF_STATUS) && wdata_in[`SLTX_ST_REALIGNED])
        realigned_reg <= 1'b0;
    end
  end

  // read port: data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rdata_next : 8'h00;
    end
  end

  // link steering; enable, reset and power-down move together so the
  // core never runs with its serializers off
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_enable_out <= 1'b0;
      link_reset_n_out <= 1'b0;
      serializer_pd_out <= 1'b1;
      timestamp_receiver_enable_out <= 1'b0;
    end else if (ce_in) begin
      link_enable_out <= link_enable_reg;
      link_reset_n_out <= link_enable_reg;
      serializer_pd_out <= ~link_enable_reg;
      timestamp_receiver_enable_out <= ts_recv_en_reg;
    end
  end

  // sync request to the core; held asserted through reset so the
  // receiver sees a clean request when the link comes up
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_request_n_out <= 1'b0;
    end else if (ce_in) begin
      sync_request_n_out <= sync_n_next;
    end
  end

  // pattern code without the reserved upper bits
  wire [3:0] pat_code = test_pattern_select_reg[`SLTX_PAT_MSB:0];

  // sample and lane settings
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sample_code_form_out <= 1'b1;
      whitening_enable_out <= 1'b0;
      lane_pattern_mode_out <= `SLTX_PAT_NORMAL;
      lane_force_low_out <= 1'b0;
      lane_force_high_out <= 1'b0;
    end else if (ce_in) begin
      sample_code_form_out <= link_control_reg[`SLTX_CTL_FORMAT];
      whitening_enable_out <= link_control_reg[`SLTX_CTL_WHITEN];
      // reserved codes map to normal data, so a stray write cannot
      // leave the lanes in an undefined state
      lane_pattern_mode_out <= (pat_code > `SLTX_PAT_HIGH) ? `SLTX_PAT_NORMAL : pat_code;
      lane_force_low_out <= (pat_code == `SLTX_PAT_LOW);
      lane_force_high_out <= (pat_code == `SLTX_PAT_HIGH);
    end
  end

  // lane alignment identifiers and the frame-end symbol
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_a_dev_id_out <= 8'h00;
      link_b_dev_id_out <= 8'h00;
      end_of_frame_symbol_out <= `SLTX_SYM_K287;
      frame_end_insert_out <= 1'b0;
    end else if (ce_in) begin
      link_a_dev_id_out <= device_identifier_param_reg;
      // the low bit is always 0, so the plus one never carries
      link_b_dev_id_out <= device_identifier_param_reg + 8'h01;
      end_of_frame_symbol_out <= eof_next;
      // only substitute where the core says the frame end allows it
      frame_end_insert_out <= frame_end_ok_in & link_enable_reg;
    end
  end
endmodule

// ### rtl/sltx_sync2.v
// two-flop synchroniser for pins from outside the clock domain
module sltx_sync2 (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire async_in,
  output reg sync_out
);
  reg meta_reg;

  // first stage feeds only the second
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (ce_in) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ### verification/sltx_far_end.sv
module sltx_far_end (
  input wire clk_in,
  output reg se_pin_out,
  output reg ts_pin_out,
  output reg lock_out,
  output reg up_out,
  output reg realign_out,
  output reg event_out,
  output reg frame_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] slot_reg = 2'h0;
  initial begin
    {se_pin_out, ts_pin_out, lock_out, up_out, realign_out, event_out, frame_ok_out} = '0;
  end
  // substitution chance one frame in four, so insertion stays opportunistic
  always @(posedge clk_in) begin
    slot_reg <= slot_reg + 2'h1;
    frame_ok_out <= up_out && slot_reg == 2'h3;
  end
  // levels move just after an edge
  task set_levels(input logic se, input logic ts, input logic lock, input logic up);
    @(posedge clk_in);
    se_pin_out <= se;
    ts_pin_out <= ts;
    lock_out <= lock;
    up_out <= up;
  endtask
  // one-cycle sysref pulses
  task pulse(input logic re, input logic ev);
    @(posedge clk_in);
    realign_out <= re;
    event_out <= ev;
    @(posedge clk_in);
    realign_out <= 1'b0;
    event_out <= 1'b0;
  endtask
endmodule

// ### verification/sltx_regs_asserts.sv
`include "sltx_consts.vh"
module sltx_regs_asserts (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [11:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire frame_end_ok_in,
  input wire link_enable_out,
  input wire link_reset_n_out,
  input wire serializer_pd_out,
  input wire sample_code_form_out,
  input wire whitening_enable_out,
  input wire [3:0] lane_pattern_mode_out,
  input wire lane_force_low_out,
  input wire lane_force_high_out,
  input wire [7:0] link_a_dev_id_out,
  input wire [7:0] link_b_dev_id_out,
  input wire [7:0] end_of_frame_symbol_out,
  input wire frame_end_insert_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // write decodes; derived outputs trail the register by one cycle
  wire wr_ctl = ce_in && wr_in && addr_in == `SLTX_OFF_CONTROL;
  wire wr_pat = ce_in && wr_in && addr_in == `SLTX_OFF_PATTERN;
  wire wr_id = ce_in && wr_in && addr_in == `SLTX_OFF_DEV_ID;
  wire wr_sym = ce_in && wr_in && addr_in == `SLTX_OFF_FRAME_SYM;
  a_whiten_follow: assert property (
    wr_ctl |=> ##1 whitening_enable_out == $past(wdata_in[0], 2)) else $error("whitening wrong");
  a_format_follow: assert property (
    wr_ctl |=> ##1 sample_code_form_out == $past(wdata_in[1], 2)) else $error("format wrong");
  a_pattern_low: assert property (
    wr_pat && wdata_in[3:0] == `SLTX_PAT_LOW |=> ##1 lane_force_low_out && !lane_force_high_out)
    else $error("force low wrong");
  a_pattern_reserved: assert property (
    wr_pat && wdata_in[3:0] > `SLTX_PAT_HIGH |=> ##1 lane_pattern_mode_out == `SLTX_PAT_NORMAL)
    else $error("reserved pattern passed");
  a_dev_id_pair: assert property (
    wr_id |=> ##1 link_a_dev_id_out == {$past(wdata_in[7:1], 2), 1'b0}
    && link_b_dev_id_out == {$past(wdata_in[7:1], 2), 1'b1}) else $error("id pair wrong");
  a_eof_symbol: assert property (
    wr_sym && wdata_in[1:0] == `SLTX_FS_K281 |=> ##1 end_of_frame_symbol_out == `SLTX_SYM_K281)
    else $error("frame symbol wrong");
  a_link_off_hold: assert property (
    !link_enable_out |-> !link_reset_n_out && serializer_pd_out) else $error("link not held");
  a_insert_cause: assert property (
    $rose(frame_end_insert_out) |-> $past(frame_end_ok_in)) else $error("insert without cause");
endmodule

// ### verification/sltx_regs_tb_top.sv
`include "sltx_consts.vh"
module sltx_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [11:0] LEN = `SLTX_OFF_LINK_EN, SYN = `SLTX_OFF_SOFT_SYNC, CTL = `SLTX_OFF_CONTROL;
  localparam [11:0] PAT = `SLTX_OFF_PATTERN, IDR = `SLTX_OFF_DEV_ID, SYM = `SLTX_OFF_FRAME_SYM;
  localparam [11:0] STS = `SLTX_OFF_STATUS, TSR = `SLTX_OFF_TS_RECV;
  reg clk_in, rst_n_in = 0, ce_in = 1, wr_in = 0, rd_in = 0, rd_seen = 0;
  reg [11:0] addr_in = 0;
  reg [7:0] wdata_in = 0, d;
  wire [7:0] rdata, id_a, id_b, eof;
  wire [3:0] mode;
  wire se, ts, lock, up, re, ev, fok, len, rst_n, pd, sync_n, fmt, whiten, low, high, ins, tsr;
  integer fail_count = 0, comparisons = 0, seed = 32'heb536bab, i;
  logic [7:0] exp_q[$];
  logic [7:0] sym_tab [0:3] = '{`SLTX_SYM_K287, `SLTX_SYM_K281, `SLTX_SYM_K285, `SLTX_SYM_K287};
  sltx_regs i_sltx_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .single_ended_sync_pin_in(se),
    .timestamp_diff_pin_in(ts), .pll_locked_in(lock), .link_up_in(up), .sysref_realign_in(re),
    .sysref_event_in(ev), .frame_end_ok_in(fok), .link_enable_out(len), .link_reset_n_out(rst_n),
    .serializer_pd_out(pd), .sync_request_n_out(sync_n), .sample_code_form_out(fmt),
    .whitening_enable_out(whiten), .lane_pattern_mode_out(mode), .lane_force_low_out(low),
    .lane_force_high_out(high), .link_a_dev_id_out(id_a), .link_b_dev_id_out(id_b),
    .end_of_frame_symbol_out(eof), .frame_end_insert_out(ins), .timestamp_receiver_enable_out(tsr));
  sltx_far_end i_sltx_far_end (.clk_in(clk_in), .se_pin_out(se), .ts_pin_out(ts), .lock_out(lock),
    .up_out(up), .realign_out(re), .event_out(ev), .frame_ok_out(fok));
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count = fail_count + 1;
    end
  endtask
  task chk1(input string name, input logic exp, input logic got);
    chk(name, {7'h0, exp}, {7'h0, got});
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    exp_q.push_back(v);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask
  // long enough for the pin synchronisers too
  task settle;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task final_report;
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // read answers stand for one cycle only, so take the oldest note there
  always @(posedge clk_in) begin
    if (rd_seen && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), rdata);
    rd_seen <= rd_in;
  end
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(CTL, `SLTX_RST_CONTROL);
    rd(PAT, `SLTX_RST_PATTERN);
    rd(IDR, `SLTX_RST_DEV_ID);
    rd(SYM, `SLTX_RST_FRAME_SYM);
    rd(LEN, 8'h01);
    rd(SYN, 8'h01);
    rd(12'h210, 8'h00);
    chk1("fmt", 1'b1, fmt);
    wr(LEN, 8'h00);
    settle;
    chk1("rst_n", 1'b0, rst_n);
    chk1("pd", 1'b1, pd);
    chk1("len", 1'b0, len);
    for (i = 0; i < 4; i++) begin
      wr(CTL, 8'h08 | i[7:0]);
      rd(CTL, 8'h08 | i[7:0]);
      settle;
      chk1("whiten", i[0], whiten);
      chk1("fmt", i[1], fmt);
    end
    for (i = 0; i < 16; i++) begin
      wr(PAT, i[7:0]);
      settle;
      chk("mode", (i > 11) ? 8'h00 : i[7:0], {4'h0, mode});
      chk1("low", i == 10, low);
      chk1("high", i == 11, high);
    end
    repeat (3) begin
      d = 8'($random(seed));
      wr(IDR, d);
      rd(IDR, d & 8'hfe);
      settle;
      chk("id_a", d & 8'hfe, id_a);
      chk("id_b", d | 8'h01, id_b);
    end
    for (i = 0; i < 4; i++) begin
      wr(SYM, i[7:0]);
      settle;
      chk("eof", sym_tab[i], eof);
    end
    // a write while the clock enable is low must be lost
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(PAT, 8'h05);
    @(posedge clk_in);
    ce_in <= 1'b1;
    settle;
    chk("mode", 8'h00, {4'h0, mode});
    rd(PAT, 8'h0f);
    wr(SYM, 8'h00);
    wr(CTL, 8'h02);
    i_sltx_far_end.set_levels(1'b0, 1'b1, 1'b1, 1'b0);
    settle;
    chk1("sync_n", 1'b0, sync_n);
    rd(STS, 8'h04);
    i_sltx_far_end.set_levels(1'b1, 1'b0, 1'b1, 1'b0);
    settle;
    chk1("sync_n", 1'b1, sync_n);
    wr(TSR, 8'h01);
    wr(CTL, 8'h06);
    settle;
    chk1("tsr", 1'b1, tsr);
    chk1("sync_n", 1'b0, sync_n);
    wr(CTL, 8'h0a);
    i_sltx_far_end.set_levels(1'b0, 1'b0, 1'b1, 1'b0);
    settle;
    chk1("sync_n", 1'b1, sync_n);
    wr(SYN, 8'h00);
    settle;
    chk1("sync_n", 1'b0, sync_n);
    rd(STS, 8'h04);
    wr(SYN, 8'h01);
    wr(LEN, 8'h01);
    i_sltx_far_end.set_levels(1'b1, 1'b1, 1'b1, 1'b1);
    settle;
    rd(STS, 8'h64);
    // insertion follows each substitution chance one cycle later
    repeat (8) begin
      @(posedge clk_in);
      d[0] = fok;
      #1;
      chk1("ins", d[0], ins);
    end
    chk1("len", 1'b1, len);
    i_sltx_far_end.pulse(1'b0, 1'b1);
    rd(STS, 8'h6c);
    i_sltx_far_end.pulse(1'b1, 1'b0);
    rd(STS, 8'h7c);
    wr(STS, 8'h00);
    rd(STS, 8'h7c);
    wr(STS, 8'hff);
    i_sltx_far_end.pulse(1'b0, 1'b1);
    rd(STS, 8'h64);
    // realign pulse and clear in one cycle: the set wins
    fork
      wr(STS, 8'h10);
      i_sltx_far_end.pulse(1'b1, 1'b0);
    join
    rd(STS, 8'h74);
    repeat (3) @(posedge clk_in);
    final_report;
  end
endmodule
bind sltx_regs sltx_regs_asserts i_sltx_regs_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .frame_end_ok_in(frame_end_ok_in),
  .link_enable_out(link_enable_out), .link_reset_n_out(link_reset_n_out),
  .serializer_pd_out(serializer_pd_out), .sample_code_form_out(sample_code_form_out),
  .whitening_enable_out(whitening_enable_out), .lane_pattern_mode_out(lane_pattern_mode_out),
  .lane_force_low_out(lane_force_low_out), .lane_force_high_out(lane_force_high_out),
  .link_a_dev_id_out(link_a_dev_id_out), .link_b_dev_id_out(link_b_dev_id_out),
  .end_of_frame_symbol_out(end_of_frame_symbol_out), .frame_end_insert_out(frame_end_insert_out));
